/* common/vfr_cfg.svh */
// Constants of the video FIFO read controller: decode values and timing counts.
// Assumes inclusion by the package and design files by bare name.
//
// Contract
// - Decode full, upper and lower read windows.
// - Three selectable burst strobe schemes supported.
// - Clocked scheme steps reads on clock-out rises under bank-three select.
// - Synchronise select; present datum one clock early.
// - Async strobe is bit two XOR delayed copy.
// - Row bank four qualifies column strobe zero.
// - Detect refresh cycles; suppress column strobes meanwhile.
// - Strobe is output enable, row and column.
`ifndef VFR_CFG_SVH
`define VFR_CFG_SVH

// ----------------------------------------------------------------------------
// Window encodings on {window_select_hi_bit, window_select_lo_bit}.
// ----------------------------------------------------------------------------
`define VFR_WIN_FULL      2'h0
`define VFR_WIN_LOWER     2'h1
`define VFR_WIN_UPPER     2'h2
`define VFR_WIN_NONE      2'h3

// ----------------------------------------------------------------------------
// Widths and timing.
// ----------------------------------------------------------------------------
`define VFR_HALF_W        16
`define VFR_FIFO_DEPTH    16
`define VFR_CLK_PERIOD_NS 100
`define VFR_A2_DELAY_NS   15
`define VFR_A2_DELAY_CYC  ((`VFR_A2_DELAY_NS + `VFR_CLK_PERIOD_NS - 1) / `VFR_CLK_PERIOD_NS)

`endif

/* common/vfr_pkg.sv */
// Types shared by the video FIFO read controller files.
// Assumes vfr_cfg.svh is on the include path.
`include "vfr_cfg.svh"

package vfr_pkg;

  // --------------------------------------------------------------------------
  // Strobe schemes and sequencer states.
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    VFR_SCHEME_CLOCKED = 2'h0,
    VFR_SCHEME_ASYNC   = 2'h1,
    VFR_SCHEME_COLUMN  = 2'h2
  } vfr_scheme_e;

  typedef enum logic [1:0] {
    VFR_ST_IDLE  = 2'h0,
    VFR_ST_PRIME = 2'h1,
    VFR_ST_BURST = 2'h3,
    VFR_ST_DONE  = 2'h2
  } vfr_state_e;

  // --------------------------------------------------------------------------
  // Host memory bus pins seen by the block.
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic static_bank_three_select_n;
    logic address_bit_two;
    logic window_select_hi_bit;
    logic window_select_lo_bit;
    logic row_bank_four_select_n;
    logic column_strobe_zero_n;
    logic output_enable_n;
    logic clock_out_pin;
  } vfr_bus_s;

  typedef struct packed {
    logic [`VFR_HALF_W-1:0] hi;
    logic [`VFR_HALF_W-1:0] lo;
  } vfr_word_s;

endpackage : vfr_pkg

/* src/vfr_fifo.sv */
// Synchronous FIFO with registered read data, valid and ready on both sides.
// Assumes one clock, synchronous active-high reset and a clock enable.
`timescale 1ns/1ps

module vfr_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 16
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop_mem;

  // --------------------------------------------------------------------------
  // Storage holds the words behind the output register.
  // --------------------------------------------------------------------------
  assign in_ready = ((cnt_q + (AW+1)'(out_valid)) != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign push     = in_valid & in_ready;
  assign pop_mem  = (cnt_q != '0) & (~out_valid | out_ready);

  always_ff @(posedge sys_clk) begin
    if (ce & push) begin
      mem[wr_q] <= in_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_q      <= '0;
      rd_q      <= '0;
      cnt_q     <= '0;
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (ce) begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
      end
      if (pop_mem) begin
        rd_q     <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
        out_data <= mem[rd_q];
      end
      cnt_q     <= cnt_q + (AW+1)'(push) - (AW+1)'(pop_mem);
      out_valid <= pop_mem | (out_valid & ~out_ready);
    end
  end

endmodule : vfr_fifo

/* src/vfr_read_ctrl.sv */
// Video FIFO read controller: window decode and burst read strobe generation.
// Assumes bus pins synchronous to sys_clk and a first-word fall-through FIFO.
`timescale 1ns/1ps
`include "vfr_cfg.svh"


module vfr_read_ctrl #(
  parameter int DEPTH   = `VFR_FIFO_DEPTH,
  parameter int DLY_CYC = `VFR_A2_DELAY_CYC
) (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              ce,
  input  vfr_pkg::vfr_scheme_e   scheme,
  input  vfr_pkg::vfr_bus_s      bus,
  input  vfr_pkg::vfr_word_s     fifo_data,
  output logic                   fifo_hi_rd,
  output logic                   fifo_lo_rd,
  output logic                   refresh_seen,
  output vfr_pkg::vfr_word_s     host_data,
  output logic                   host_valid,
  input  wire logic              host_ready,
  output logic                   buf_full
);
  import vfr_pkg::*;

  // --------------------------------------------------------------------------
  // Window decode.
  // --------------------------------------------------------------------------
  function automatic logic [1:0] lanes_of(input logic [1:0] win);
    unique case (win)
      `VFR_WIN_FULL:  lanes_of = 2'h3;
      `VFR_WIN_UPPER: lanes_of = 2'h2;
      `VFR_WIN_LOWER: lanes_of = 2'h1;
      default:        lanes_of = 2'h0;
    endcase
  endfunction : lanes_of

  logic [1:0] lanes;
  assign lanes = lanes_of({bus.window_select_hi_bit, bus.window_select_lo_bit});

  // --------------------------------------------------------------------------
  // Clocked select sequencer.
  // --------------------------------------------------------------------------
  logic       cs_s1_q;
  logic       cs_s2_q;
  logic       rclk_q;
  vfr_state_e st_q;
  vfr_state_e st_d;
  logic       cs_act;
  logic       rclk_rise;
  logic       clk_strobe;
  logic       seq_on;
  logic       async_on;
  logic       col_on;

  assign seq_on    = (scheme == VFR_SCHEME_CLOCKED);
  assign async_on  = (scheme == VFR_SCHEME_ASYNC);
  assign col_on    = (scheme == VFR_SCHEME_COLUMN);
  assign cs_act    = ~cs_s2_q;
  assign rclk_rise = bus.clock_out_pin & ~rclk_q;

  always_comb begin
    st_d       = st_q;
    clk_strobe = 1'b0;
    unique case (st_q)
      VFR_ST_IDLE: begin
        if (cs_act) begin
          st_d       = VFR_ST_PRIME;
          clk_strobe = 1'b1;
        end
      end
      VFR_ST_PRIME: begin
        st_d = cs_act ? VFR_ST_BURST : VFR_ST_DONE;
      end
      VFR_ST_BURST: begin
        if (!cs_act) begin
          st_d = VFR_ST_DONE;
        end else begin
          clk_strobe = rclk_rise;
        end
      end
      VFR_ST_DONE: begin
        st_d = VFR_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
    end else if (ce) begin
      cs_s1_q <= bus.static_bank_three_select_n;
      cs_s2_q <= cs_s1_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rclk_q <= 1'b0;
    end else if (ce) begin
      rclk_q <= bus.clock_out_pin;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_q <= VFR_ST_IDLE;
    end else if (ce) begin
      st_q <= seq_on ? st_d : VFR_ST_IDLE;
    end
  end

  // --------------------------------------------------------------------------
  // Address-line timed scheme.
  // --------------------------------------------------------------------------
  logic [DLY_CYC-1:0] a2_dly_q;
  logic               async_strobe;

  assign async_strobe = ~bus.static_bank_three_select_n
                      & (bus.address_bit_two ^ a2_dly_q[DLY_CYC-1]);

  generate
    for (genvar i = 0; i < DLY_CYC; i++) begin : g_a2_dly
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          a2_dly_q[i] <= 1'b0;
        end else if (ce) begin
          a2_dly_q[i] <= (i == 0) ? bus.address_bit_two : a2_dly_q[(i == 0) ? 0 : i-1];
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Column strobe scheme with refresh blocking.
  // --------------------------------------------------------------------------
  logic cas_q;
  logic ras_act;
  logic cas_act;
  logic cbr_now;
  logic col_strobe;
  logic refresh_d;

  assign ras_act    = ~bus.row_bank_four_select_n;
  assign cas_act    = ~bus.column_strobe_zero_n;
  assign cbr_now    = cas_act & ~ras_act;
  assign col_strobe = cas_act & ~cas_q & ras_act
                    & ~bus.output_enable_n
                    & ~refresh_seen & ~cbr_now;
  assign refresh_d  = cbr_now | (refresh_seen & (ras_act | cas_act));

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cas_q <= 1'b0;
    end else if (ce) begin
      cas_q <= cas_act;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      refresh_seen <= 1'b0;
    end else if (ce) begin
      refresh_seen <= refresh_d;
    end
  end

  // --------------------------------------------------------------------------
  // Scheme select, buffering and strobe outputs.
  // --------------------------------------------------------------------------
  logic      raw_strobe;
  logic      take;
  logic      in_ready;
  vfr_word_s push_word;
  logic      hi_take;
  logic      lo_take;

  assign raw_strobe = seq_on   ? clk_strobe   :
                      async_on ? async_strobe :
                      col_on   ? col_strobe   : 1'b0;
  assign take       = raw_strobe & (lanes != 2'h0) & in_ready;
  assign hi_take    = take & lanes[1];
  assign lo_take    = take & lanes[0];
  assign push_word.hi = lanes[1] ? fifo_data.hi : 16'h0000;
  assign push_word.lo = lanes[0] ? fifo_data.lo : 16'h0000;

  vfr_fifo #(
    .W     ($bits(vfr_word_s)),
    .DEPTH (DEPTH)
  ) u_buf (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .ce        (ce),
    .in_data   (push_word),
    .in_valid  (take),
    .in_ready  (in_ready),
    .out_data  (host_data),
    .out_valid (host_valid),
    .out_ready (host_ready)
  );

  // --------------------------------------------------------------------------
  // Registered strobe and status outputs.
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fifo_hi_rd <= 1'b0;
      fifo_lo_rd <= 1'b0;
    end else if (ce) begin
      fifo_hi_rd <= hi_take;
      fifo_lo_rd <= lo_take;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      buf_full <= 1'b0;
    end else if (ce) begin
      buf_full <= ~in_ready;
    end
  end

endmodule : vfr_read_ctrl

/* testbench/vfr_fifo_model.sv */
// Model of the two external half-word FIFO chips, first-word fall-through.
// Assumes single-cycle active-high read strobes on sys_clk.
`timescale 1ns/1ps

module vfr_fifo_model (
  input wire logic           sys_clk,
  input wire logic           rst,
  input wire logic           hi_rd,
  input wire logic           lo_rd,
  output vfr_pkg::vfr_word_s data
);
  import vfr_pkg::*;
  logic [15:0] hi_q;
  logic [15:0] lo_q;
  // Each half advances only on its own strobe, so the halves may drift apart.
  assign data = {16'hA000 + hi_q, 16'h5000 + lo_q};
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hi_q <= 16'h0;
      lo_q <= 16'h0;
    end else begin
      hi_q <= hi_q + 16'(hi_rd);
      lo_q <= lo_q + 16'(lo_rd);
    end
  end
endmodule : vfr_fifo_model

/* testbench/vfr_chk.sv */
// Assertions on the ports of the video FIFO read controller.
// Assumes a bind onto vfr_read_ctrl; one clock domain.
`timescale 1ns/1ps
`include "vfr_cfg.svh"

module vfr_chk #(
  parameter int DEPTH   = 16,
  parameter int DLY_CYC = 1
) (
  input wire logic            sys_clk,
  input wire logic            rst,
  input wire logic            ce,
  input vfr_pkg::vfr_scheme_e scheme,
  input vfr_pkg::vfr_bus_s    bus,
  input vfr_pkg::vfr_word_s   fifo_data,
  input wire logic            fifo_hi_rd,
  input wire logic            fifo_lo_rd,
  input wire logic            refresh_seen,
  input vfr_pkg::vfr_word_s   host_data,
  input wire logic            host_valid,
  input wire logic            host_ready,
  input wire logic            buf_full
);
  import vfr_pkg::*;
  wire [1:0] code = {bus.window_select_hi_bit, bus.window_select_lo_bit};
  wire       col  = scheme == VFR_SCHEME_COLUMN;
  wire       rd   = fifo_hi_rd || fifo_lo_rd;
  wire       gate = !bus.output_enable_n && !bus.row_bank_four_select_n;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_col_gate: assert property (rd && $past(col)
    |-> $past(gate && !bus.column_strobe_zero_n)) else $error("column strobe ungated");
  a_hi_map: assert property (fifo_hi_rd
    |-> $past(code) == `VFR_WIN_FULL || $past(code) == `VFR_WIN_UPPER) else $error("bad hi");
  a_lo_map: assert property (fifo_lo_rd
    |-> $past(code) == `VFR_WIN_FULL || $past(code) == `VFR_WIN_LOWER) else $error("bad lo");
  a_full_pair: assert property (fifo_hi_rd ^ fifo_lo_rd
    |-> $past(code) != `VFR_WIN_FULL) else $error("full word read by one half");
  a_none_quiet: assert property ($past(code) == `VFR_WIN_NONE
    |-> !rd) else $error("strobe in unused window");
  a_refr_block: assert property (refresh_seen && col |=> !rd)
    else $error("strobe during refresh");
  a_refr_flag: assert property (col && ce && !bus.column_strobe_zero_n
    && bus.row_bank_four_select_n |=> refresh_seen) else $error("refresh not flagged");
  a_async_xor: assert property (scheme == VFR_SCHEME_ASYNC && ce && !buf_full
    && !bus.static_bank_three_select_n && code == `VFR_WIN_FULL
    && bus.address_bit_two != $past(bus.address_bit_two, DLY_CYC)
    |=> fifo_hi_rd && fifo_lo_rd) else $error("address edge gave no strobe");
endmodule : vfr_chk

bind vfr_read_ctrl vfr_chk #(.DEPTH(DEPTH), .DLY_CYC(DLY_CYC)) u_chk (
  .sys_clk(sys_clk), .rst(rst), .ce(ce), .scheme(scheme), .bus(bus),
  .fifo_data(fifo_data), .fifo_hi_rd(fifo_hi_rd), .fifo_lo_rd(fifo_lo_rd),
  .refresh_seen(refresh_seen), .host_data(host_data), .host_valid(host_valid),
  .host_ready(host_ready), .buf_full(buf_full));

/* testbench/tb_top.sv */
// Self-checking bench of the video FIFO read controller.
// Assumes the bound checker and the FIFO chip model beside the design.
`timescale 1ns/1ps

module tb_top;
  import vfr_pkg::*;
  logic        sys_clk = 0;
  logic        rst = 1;
  logic        host_ready = 0;
  logic        ce = 1;
  vfr_scheme_e scheme = VFR_SCHEME_COLUMN;
  vfr_bus_s    bus = 8'h8E;
  vfr_word_s   fifo_data, host_data;
  logic        hi_rd, lo_rd, refresh_seen, host_valid, buf_full;
  int          bad_count = 0, comparisons = 0, cycles = 0;
  int          n_hi = 0, n_lo = 0, hi_k = 0, lo_k = 0;
  always #50 sys_clk = ~sys_clk;
  vfr_read_ctrl #(.DEPTH(16), .DLY_CYC(1)) u_dut (
    .sys_clk(sys_clk), .rst(rst), .ce(ce), .scheme(scheme), .bus(bus),
    .fifo_data(fifo_data), .fifo_hi_rd(hi_rd), .fifo_lo_rd(lo_rd),
    .refresh_seen(refresh_seen), .host_data(host_data), .host_valid(host_valid),
    .host_ready(host_ready), .buf_full(buf_full));
  vfr_fifo_model u_model (.sys_clk(sys_clk), .rst(rst), .hi_rd(hi_rd), .lo_rd(lo_rd),
    .data(fifo_data));
  always @(posedge sys_clk) begin
    cycles++;
    if (hi_rd === 1'b1) n_hi++;
    if (lo_rd === 1'b1) n_lo++;
    if (cycles == 5000) begin
      bad_count++;
      test_done();
    end
  end
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic tick(int n);
    repeat (n) @(posedge sys_clk);
    #5;
  endtask : tick
  task automatic pop(logic [1:0] code);
    logic [31:0] m;
    int          w;
    m = {{16{code != 2'h1}}, {16{code != 2'h2}}};
    for (w = 0; w < 20 && host_valid !== 1'b1; w++) tick(1);
    chk("host_valid", {31'h0, host_valid}, 1);
    chk("host_data", host_data & m, {16'hA000 + hi_k[15:0], 16'h5000 + lo_k[15:0]} & m);
    hi_k += int'(m[31]);
    lo_k += int'(m[0]);
    host_ready = 1;
    tick(1);
    host_ready = 0;
    tick(1);
  endtask : pop
  task automatic col_burst(logic [1:0] code, logic oe_n, int n);
    {bus.window_select_hi_bit, bus.window_select_lo_bit} = code;
    bus.row_bank_four_select_n = 0;
    bus.output_enable_n        = oe_n;
    repeat (n) begin
      tick(3);
      bus.column_strobe_zero_n = 0;
      tick(3);
      bus.column_strobe_zero_n = 1;
    end
    tick(3);
    bus.row_bank_four_select_n = 1;
    bus.output_enable_n        = 1;
    tick(2);
  endtask : col_burst
  task automatic t_windows;
    for (int c = 0; c < 4; c++) begin
      n_hi = 0;
      n_lo = 0;
      col_burst(c[1:0], 0, 2);
      chk("hi strobes", n_hi, (c == 0 || c == 2) ? 2 : 0);
      chk("lo strobes", n_lo, (c < 2) ? 2 : 0);
      for (int i = 0; i < 2 && c != 3; i++) pop(c[1:0]);
    end
  endtask : t_windows
  task automatic t_refresh;
    n_hi = 0;
    bus.column_strobe_zero_n = 0;
    tick(1);
    bus.row_bank_four_select_n = 0;
    tick(3);
    chk("refresh_seen", {31'h0, refresh_seen}, 1);
    bus.column_strobe_zero_n   = 1;
    bus.row_bank_four_select_n = 1;
    tick(3);
    chk("refresh_seen", {31'h0, refresh_seen}, 0);
    col_burst(2'h0, 1, 2);
    chk("hi strobes", n_hi, 0);
  endtask : t_refresh
  task automatic t_async;
    scheme = VFR_SCHEME_ASYNC;
    n_hi = 0;
    n_lo = 0;
    for (int i = 0; i < 6; i++) begin
      bus.static_bank_three_select_n = (i < 2);
      bus.address_bit_two           = !bus.address_bit_two;
      tick(2);
    end
    bus.static_bank_three_select_n = 1;
    tick(2);
    chk("hi strobes", n_hi, 4);
    chk("lo strobes", n_lo, 4);
    repeat (4) pop(2'h0);
  endtask : t_async
  task automatic t_clocked;
    scheme = VFR_SCHEME_CLOCKED;
    n_hi = 0;
    bus.static_bank_three_select_n = 0;
    tick(6);
    repeat (4) begin
      bus.clock_out_pin = 1;
      tick(1);
      bus.clock_out_pin = 0;
      tick(1);
    end
    bus.static_bank_three_select_n = 1;
    tick(6);
    chk("hi strobes", n_hi, 5);
    repeat (5) pop(2'h0);
  endtask : t_clocked
  task automatic t_freeze;
    scheme = VFR_SCHEME_COLUMN;
    n_hi   = 0;
    ce     = 0;
    col_burst(2'h0, 0, 2);
    ce = 1;
    tick(2);
    chk("frozen strobes", n_hi, 0);
    chk("host_valid", {31'h0, host_valid}, 0);
    scheme = vfr_scheme_e'(2'h3);
    col_burst(2'h0, 0, 2);
    chk("scheme off strobes", n_hi, 0);
  endtask : t_freeze
  task automatic t_fill;
    int n;
    scheme = VFR_SCHEME_COLUMN;
    n_hi = 0;
    repeat (3) col_burst(2'h0, 0, 8);
    n = n_hi;
    chk("buf_full", {31'h0, buf_full}, 1);
    chk("kept", n, 16);
    repeat (n) pop(2'h0);
    tick(2);
    chk("host_valid", {31'h0, host_valid}, 0);
    chk("buf_full", {31'h0, buf_full}, 0);
  endtask : t_fill
  initial begin
    tick(8);
    rst = 0;
    tick(1);
    t_windows();
    t_refresh();
    t_async();
    t_clocked();
    t_freeze();
    t_fill();
    test_done();
  end
endmodule : tb_top
